// [rtl/lfoc_pkg.sv]
// Purpose: constants for the low-frequency oscillator control block
// Assumes: 8-bit register port, 100 MHz system clock
// Notes: crystal and ulp oscillator clocks arrive as pins and are synchronised
package lfoc_pkg;
   // register offsets
   localparam logic [7:0] ADDR_ULP_CTRL = 8'h18;
   localparam logic [7:0] ADDR_XTAL_CTRL = 8'h1C;
   localparam logic [7:0] ADDR_TEMP_CAL = 8'h12;
   localparam logic [7:0] ADDR_STATUS = 8'h03;
   localparam logic [7:0] ADDR_PROTECT = 8'h20;
   // field positions
   localparam int ULP_RUNSTBY_BIT = 1;
   localparam int XT_EN_BIT = 0;
   localparam int XT_RUN_BIT = 1;
   localparam int XT_SEL_BIT = 2;
   localparam int XT_CRYSTAL_STARTUP_COUNT_LO = 4;
   localparam int XT_CRYSTAL_STARTUP_COUNT_HI = 5;
   localparam int CAL_LOCK_BIT = 7;
   localparam int TRIM_HI = 3;
   localparam int STAT_XT_BIT = 6;
   localparam int STAT_ULP_BIT = 5;
   // reset values
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [3:0] TRIM_FREQ16 = 4'h7;
   localparam logic [3:0] TRIM_FREQ20 = 4'h8;
   // unlock key for protected bits
   localparam logic [7:0] PROTECT_KEY = 8'hD8;
   localparam logic [2:0] PROTECT_WINDOW = 3'h4;
   // startup counts in oscillator cycles
   localparam logic [16:0] CRYSTAL_STARTUP_COUNT_1K = 17'h00400;
   localparam logic [16:0] CRYSTAL_STARTUP_COUNT_16K = 17'h04000;
   localparam logic [16:0] CRYSTAL_STARTUP_COUNT_32K = 17'h08000;
   localparam logic [16:0] CRYSTAL_STARTUP_COUNT_64K = 17'h10000;
   localparam logic [2:0] ULP_GATE_CYCLES = 3'h4;
   localparam logic [1:0] XT_GATE_CYCLES = 2'h2;
   localparam logic [16:0] ULP_ANALOG_START = 17'h00040;
endpackage

// [rtl/lfoc_control.sv]
// Purpose: enable, startup, gating and status for the low-frequency oscillators
// Assumes: oscillator clocks are much slower than sys_clk_in, edges counted after sync
// Notes: protected bits need the key written to the protect register first
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
// Notes on behaviour
// - temp slope trim reset from frequency fuse
// - ulp keep running keeps oscillator powered
// - ulp output only while requested
// - ulp gate opens after 4 cycles
// - select and count locked while enabled/stable
// - startup count codes 1k 16k 32k 64k
// - external clock skips startup count
// - select 0 crystal, 1 external clock
// - keep running holds crystal on without request, only while enabled
// - crystal output only while requested
// - kept running crystal delivers in 2-3 cycles
// - enable and keep running write protected
// - enable hands both pins to oscillator
// - stable reported only while requested
// - calibration lock blocks trim writes
module lfoc_control (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // register port
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   // fuses
   input wire logic freq_select_fuse_in,
   input wire logic cal_lock_fuse_in,
   // consumer requests
   input wire logic [3:0] ulp_req_in,
   input wire logic [3:0] xtal_req_in,
   // oscillator clocks as seen from the pins
   input wire logic ulp_clk_in,
   input wire logic crystal_pin_in,
   // oscillator and pin control
   output logic ulp_power_out,
   output logic ulp_gate_out,
   output logic xtal_power_out,
   output logic xtal_gate_out,
   output logic xtal_ext_clock_out,
   output logic pin_override_out,
   output logic [3:0] temp_slope_trim_out
);
   // ----------------------------------------------------------------
   // pin synchronisers and edge detect
   // ----------------------------------------------------------------
   logic [2:0] ulp_sync, next_ulp_sync;
   logic [2:0] xt_sync, next_xt_sync;
   logic ulp_edge, xt_edge;
   always_comb begin
      next_ulp_sync = {ulp_sync[1:0], ulp_clk_in};
      next_xt_sync = {xt_sync[1:0], crystal_pin_in};
      ulp_edge = ulp_sync[1] & ~ulp_sync[2];
      xt_edge = xt_sync[1] & ~xt_sync[2];
   end
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         ulp_sync <= 3'h0;
         xt_sync <= 3'h0;
      end else begin
         ulp_sync <= next_ulp_sync;
         xt_sync <= next_xt_sync;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic ulp_keep, next_ulp_keep;
   logic xt_en, next_xt_en;
   logic xt_keep, next_xt_keep;
   logic xt_sel, next_xt_sel;
   logic [1:0] xt_crystal_startup_count, next_xt_crystal_startup_count;
   logic [3:0] trim, next_trim;
   logic cal_lock, next_cal_lock;
   logic trim_loaded, next_trim_loaded;
   logic [2:0] unlock_cnt, next_unlock_cnt;
   logic [7:0] rdata, next_rdata;
   logic xt_stable_raw, xt_stat, ulp_stat;
   logic ulp_req, xt_req;
   logic unlocked;

   assign ulp_req = |ulp_req_in;
   assign xt_req = |xtal_req_in;
   assign unlocked = unlock_cnt != 3'h0;

   always_comb begin
      next_ulp_keep = ulp_keep;
      next_xt_en = xt_en;
      next_xt_keep = xt_keep;
      next_xt_sel = xt_sel;
      next_xt_crystal_startup_count = xt_crystal_startup_count;
      next_trim = trim;
      next_cal_lock = cal_lock;
      next_trim_loaded = 1'b1;
      next_unlock_cnt = unlocked ? unlock_cnt - 3'h1 : 3'h0;
      // fuse values are caught on the first clock after reset release
      if (!trim_loaded) begin
         next_trim = freq_select_fuse_in ? lfoc_pkg::TRIM_FREQ20
                                         : lfoc_pkg::TRIM_FREQ16;
         next_cal_lock = cal_lock_fuse_in;
      end
      if (wr_in) begin
         if (addr_in == lfoc_pkg::ADDR_PROTECT && wdata_in == lfoc_pkg::PROTECT_KEY) begin
            next_unlock_cnt = lfoc_pkg::PROTECT_WINDOW;
         end
         if (addr_in == lfoc_pkg::ADDR_ULP_CTRL) begin
            next_ulp_keep = wdata_in[lfoc_pkg::ULP_RUNSTBY_BIT];
         end
         if (addr_in == lfoc_pkg::ADDR_XTAL_CTRL) begin
            if (unlocked) begin
               next_xt_en = wdata_in[lfoc_pkg::XT_EN_BIT];
               next_xt_keep = wdata_in[lfoc_pkg::XT_RUN_BIT];
               next_unlock_cnt = 3'h0;
            end
            if (!xt_en && !xt_stable_raw) begin
               next_xt_sel = wdata_in[lfoc_pkg::XT_SEL_BIT];
               next_xt_crystal_startup_count = wdata_in[lfoc_pkg::XT_CRYSTAL_STARTUP_COUNT_HI:lfoc_pkg::XT_CRYSTAL_STARTUP_COUNT_LO];
            end
         end
         if (addr_in == lfoc_pkg::ADDR_TEMP_CAL && !cal_lock && trim_loaded) begin
            next_trim = wdata_in[lfoc_pkg::TRIM_HI:0];
         end
      end
      next_rdata = 8'h00;
      if (rd_in) begin
         case (addr_in)
            lfoc_pkg::ADDR_ULP_CTRL: next_rdata[lfoc_pkg::ULP_RUNSTBY_BIT] = ulp_keep;
            lfoc_pkg::ADDR_XTAL_CTRL: begin
               next_rdata[lfoc_pkg::XT_EN_BIT] = xt_en;
               next_rdata[lfoc_pkg::XT_RUN_BIT] = xt_keep;
               next_rdata[lfoc_pkg::XT_SEL_BIT] = xt_sel;
               next_rdata[lfoc_pkg::XT_CRYSTAL_STARTUP_COUNT_HI:lfoc_pkg::XT_CRYSTAL_STARTUP_COUNT_LO] = xt_crystal_startup_count;
            end
            lfoc_pkg::ADDR_TEMP_CAL: begin
               next_rdata[lfoc_pkg::CAL_LOCK_BIT] = cal_lock;
               next_rdata[lfoc_pkg::TRIM_HI:0] = trim;
            end
            lfoc_pkg::ADDR_STATUS: begin
               next_rdata[lfoc_pkg::STAT_XT_BIT] = xt_stat;
               next_rdata[lfoc_pkg::STAT_ULP_BIT] = ulp_stat;
            end
            default: next_rdata = 8'h00;
         endcase
      end
   end
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         ulp_keep <= 1'b0;
         xt_en <= 1'b0;
         xt_keep <= 1'b0;
         xt_sel <= 1'b0;
         xt_crystal_startup_count <= 2'h0;
         trim <= 4'h0;
         cal_lock <= 1'b1;
         trim_loaded <= 1'b0;
         unlock_cnt <= 3'h0;
         rdata <= lfoc_pkg::RST_CTRL;
      end else begin
         ulp_keep <= next_ulp_keep;
         xt_en <= next_xt_en;
         xt_keep <= next_xt_keep;
         xt_sel <= next_xt_sel;
         xt_crystal_startup_count <= next_xt_crystal_startup_count;
         trim <= next_trim;
         cal_lock <= next_cal_lock;
         trim_loaded <= next_trim_loaded;
         unlock_cnt <= next_unlock_cnt;
         rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // ultra-low-power oscillator
   // ----------------------------------------------------------------
   // analog start-up is modelled as a fixed edge count, skipped when kept running
   logic ulp_on;
   logic ulp_ready, next_ulp_ready;
   logic [16:0] ulp_cnt, next_ulp_cnt;
   logic [2:0] ulp_gcnt, next_ulp_gcnt;
   logic ulp_gate, next_ulp_gate;
   assign ulp_on = ulp_keep | ulp_req;
   always_comb begin
      next_ulp_cnt = ulp_cnt;
      next_ulp_ready = ulp_ready;
      next_ulp_gcnt = ulp_gcnt;
      next_ulp_gate = ulp_gate;
      if (!ulp_on) begin
         next_ulp_cnt = 17'h0;
         next_ulp_ready = 1'b0;
      end else if (ulp_keep) begin
         next_ulp_ready = 1'b1;
      end else if (ulp_edge && !ulp_ready) begin
         next_ulp_cnt = ulp_cnt + 17'h1;
         next_ulp_ready = ulp_cnt + 17'h1 >= lfoc_pkg::ULP_ANALOG_START;
      end
      if (!ulp_req) begin
         next_ulp_gcnt = 3'h0;
         next_ulp_gate = 1'b0;
      end else if (ulp_ready && ulp_edge && !ulp_gate) begin
         next_ulp_gcnt = ulp_gcnt + 3'h1;
         next_ulp_gate = ulp_gcnt + 3'h1 >= lfoc_pkg::ULP_GATE_CYCLES;
      end
   end
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         ulp_cnt <= 17'h0;
         ulp_ready <= 1'b0;
         ulp_gcnt <= 3'h0;
         ulp_gate <= 1'b0;
      end else begin
         ulp_cnt <= next_ulp_cnt;
         ulp_ready <= next_ulp_ready;
         ulp_gcnt <= next_ulp_gcnt;
         ulp_gate <= next_ulp_gate;
      end
   end

   // ----------------------------------------------------------------
   // crystal oscillator
   // ----------------------------------------------------------------
   logic xt_on;
   logic xt_ready, next_xt_ready;
   logic [16:0] xt_cnt, next_xt_cnt;
   logic [16:0] xt_target;
   logic [1:0] xt_gcnt, next_xt_gcnt;
   logic xt_gate, next_xt_gate;
   assign xt_on = xt_en & (xt_keep | xt_req);
   always_comb begin
      case (xt_crystal_startup_count)
         2'h0: xt_target = lfoc_pkg::CRYSTAL_STARTUP_COUNT_1K;
         2'h1: xt_target = lfoc_pkg::CRYSTAL_STARTUP_COUNT_16K;
         2'h2: xt_target = lfoc_pkg::CRYSTAL_STARTUP_COUNT_32K;
         default: xt_target = lfoc_pkg::CRYSTAL_STARTUP_COUNT_64K;
      endcase
      next_xt_cnt = xt_cnt;
      next_xt_ready = xt_ready;
      next_xt_gcnt = xt_gcnt;
      next_xt_gate = xt_gate;
      if (!xt_on) begin
         next_xt_cnt = 17'h0;
         next_xt_ready = 1'b0;
      end else if (xt_sel) begin
         next_xt_ready = xt_edge | xt_ready;
      end else if (xt_edge && !xt_ready) begin
         next_xt_cnt = xt_cnt + 17'h1;
         next_xt_ready = xt_cnt + 17'h1 >= xt_target;
      end
      if (!xt_req || !xt_on) begin
         next_xt_gcnt = 2'h0;
         next_xt_gate = 1'b0;
      end else if (xt_ready && xt_edge && !xt_gate) begin
         next_xt_gcnt = xt_gcnt + 2'h1;
         next_xt_gate = xt_gcnt + 2'h1 >= lfoc_pkg::XT_GATE_CYCLES;
      end
   end
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         xt_cnt <= 17'h0;
         xt_ready <= 1'b0;
         xt_gcnt <= 2'h0;
         xt_gate <= 1'b0;
      end else begin
         xt_cnt <= next_xt_cnt;
         xt_ready <= next_xt_ready;
         xt_gcnt <= next_xt_gcnt;
         xt_gate <= next_xt_gate;
      end
   end

   // ----------------------------------------------------------------
   // status and outputs
   // ----------------------------------------------------------------
   // stable flag holds the select/count lock until a disabled crystal has stopped
   assign xt_stable_raw = xt_ready;
   assign xt_stat = xt_ready & xt_req;
   assign ulp_stat = ulp_ready & ulp_req;
   assign rdata_out = rdata;
   assign ulp_power_out = ulp_on;
   assign ulp_gate_out = ulp_gate;
   assign xtal_power_out = xt_on & ~xt_sel;
   assign xtal_gate_out = xt_gate;
   assign xtal_ext_clock_out = xt_sel;
   assign pin_override_out = xt_en;
   assign temp_slope_trim_out = trim;
endmodule

// [testbench/lfoc_control_sva.sv]
// Purpose: port-level checker for lfoc_control
// Assumes: oscillator models toggle no faster than every 2 sys_clk_in cycles
// Notes: attached by the bind below the module
`timescale 1ns/1ps
module lfoc_control_sva (
   // clock, reset and bus
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic [7:0] addr_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   // fuses and requests
   input wire logic cal_lock_fuse_in,
   input wire logic [3:0] ulp_req_in,
   input wire logic [3:0] xtal_req_in,
   // controls
   input wire logic ulp_power_out,
   input wire logic ulp_gate_out,
   input wire logic xtal_power_out,
   input wire logic xtal_gate_out,
   input wire logic xtal_ext_clock_out,
   input wire logic pin_override_out,
   input wire logic [3:0] temp_slope_trim_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   property p_ulp_off; !(|ulp_req_in) [*3] |-> !ulp_gate_out; endproperty
   a_ulp_off: assert property (p_ulp_off) else $error("ulp gate open unrequested");
   property p_ulp_wait; $rose(ulp_gate_out) |-> $past(|ulp_req_in, 8); endproperty
   a_ulp_wait: assert property (p_ulp_wait) else $error("ulp gate opened early");
   property p_ulp_pwr; (|ulp_req_in) |-> ulp_power_out; endproperty
   a_ulp_pwr: assert property (p_ulp_pwr) else $error("ulp unpowered while requested");
   property p_xt_off; !(|xtal_req_in) [*3] |-> !xtal_gate_out; endproperty
   a_xt_off: assert property (p_xt_off) else $error("crystal gate open unrequested");
   property p_xt_pwr; xtal_power_out |-> pin_override_out && !xtal_ext_clock_out; endproperty
   a_xt_pwr: assert property (p_xt_pwr) else $error("crystal driven wrongly");
   property p_pins; $rose(pin_override_out) |-> $past(wr_in && addr_in == 8'h1C); endproperty
   a_pins: assert property (p_pins) else $error("pins taken without write");
   property p_sel; $changed(xtal_ext_clock_out)
      |-> $past(wr_in && addr_in == lfoc_pkg::ADDR_XTAL_CTRL && !pin_override_out); endproperty
   a_sel: assert property (p_sel) else $error("select changed while enabled");
   property p_trim; $changed(temp_slope_trim_out) && !$past(rst_in) && !$past(rst_in, 2)
      |-> $past(wr_in && addr_in == lfoc_pkg::ADDR_TEMP_CAL && !cal_lock_fuse_in); endproperty
   a_trim: assert property (p_trim) else $error("trim changed without write");
   property p_rdata; rdata_out != 8'h00 |-> $past(rd_in); endproperty
   a_rdata: assert property (p_rdata) else $error("read data outside read slot");
endmodule
bind lfoc_control lfoc_control_sva lfoc_control_sva_inst (.sys_clk_in, .rst_in, .addr_in,
   .wr_in, .rd_in, .rdata_out, .cal_lock_fuse_in, .ulp_req_in, .xtal_req_in, .ulp_power_out,
   .ulp_gate_out, .xtal_power_out, .xtal_gate_out, .xtal_ext_clock_out, .pin_override_out,
   .temp_slope_trim_out);

// [testbench/lfoc_osc_model.sv]
// Purpose: oscillator or external clock as seen at a pin
// Assumes: toggles every HALF sys_clk_in cycles while running
// Notes: a stopped oscillator holds its level, so no edges leak out
`timescale 1ns/1ps
module lfoc_osc_model #(
   parameter int HALF = 2
) (
   // sys clock and run control
   input wire logic sys_clk_in,
   input wire logic run_in,
   // pin level
   output logic osc_out
);
   int cnt = 0;
   initial osc_out = 1'b0;
   always @(posedge sys_clk_in) begin
      if (run_in) begin
         cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
         if (cnt == HALF - 1) begin
            osc_out <= ~osc_out;
         end
      end
   end
endmodule

// [testbench/lfoc_control_tb_top.sv]
// Purpose: self-checking bench for lfoc_control
// Assumes: oscillator models with a 4-cycle period
// Notes: only the shortest start-up code is timed, to keep the run short
`timescale 1ns/1ps
module lfoc_control_tb_top;
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic freq_select_fuse_in = 1'b0;
   logic cal_lock_fuse_in = 1'b0;
   logic [3:0] ulp_req_in = 4'h0;
   logic [3:0] xtal_req_in = 4'h0;
   logic [7:0] rdata_out;
   logic ulp_clk_in, crystal_pin_in, ulp_power_out, ulp_gate_out, xtal_power_out;
   logic xtal_gate_out, xtal_ext_clock_out, pin_override_out;
   logic [3:0] temp_slope_trim_out;
   logic [7:0] rv;
   int fails = 0;
   int num_checks = 0;
   always #5 sys_clk_in = ~sys_clk_in;
   lfoc_control lfoc_control_inst (.sys_clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
      .rdata_out, .freq_select_fuse_in, .cal_lock_fuse_in, .ulp_req_in, .xtal_req_in,
      .ulp_clk_in, .crystal_pin_in, .ulp_power_out, .ulp_gate_out, .xtal_power_out,
      .xtal_gate_out, .xtal_ext_clock_out, .pin_override_out, .temp_slope_trim_out);
   lfoc_osc_model #(.HALF(2)) ulp_model_inst (.sys_clk_in, .run_in(ulp_power_out),
      .osc_out(ulp_clk_in));
   lfoc_osc_model #(.HALF(2)) xtal_model_inst (.sys_clk_in,
      .run_in(xtal_power_out | xtal_ext_clock_out), .osc_out(crystal_pin_in));
   // ----------------------------------------
   // bus and compare tasks
   // ----------------------------------------
   task automatic finish_test();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic do_reset(input logic fs, input logic lk);
      rst_in <= 1'b1;
      freq_select_fuse_in <= fs;
      cal_lock_fuse_in <= lk;
      repeat (8) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
   endtask
   // one more edge so the caller samples the written register after it has settled
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge sys_clk_in);
      wr_in <= 1'b0;
      @(posedge sys_clk_in);
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge sys_clk_in);
      rd_in <= 1'b0;
      @(posedge sys_clk_in);
      rv = rdata_out;
   endtask
   task automatic wait_stat(input int b, input logic v, input int n);
      int i;
      for (i = 0; i < n; i++) begin
         rd(lfoc_pkg::ADDR_STATUS);
         if (rv[b] === v) break;
      end
      if (i == n) begin
         fails++;
         finish_test();
      end
   endtask
   task automatic key_wr(input logic [7:0] d);
      wr(lfoc_pkg::ADDR_PROTECT, lfoc_pkg::PROTECT_KEY);
      wr(lfoc_pkg::ADDR_XTAL_CTRL, d);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      rd(lfoc_pkg::ADDR_ULP_CTRL);
      chk(rv, lfoc_pkg::RST_CTRL);
      rd(lfoc_pkg::ADDR_TEMP_CAL);
      chk(rv, {4'h0, lfoc_pkg::TRIM_FREQ16});
      rd(8'h55);
      chk(rv, 8'h00);
      wr(lfoc_pkg::ADDR_TEMP_CAL, 8'h83);
      rd(lfoc_pkg::ADDR_TEMP_CAL);
      chk(rv, 8'h03);
   endtask
   task automatic t_xtal();
      wr(lfoc_pkg::ADDR_XTAL_CTRL, 8'h03);
      chk({7'h0, pin_override_out}, 8'h00);
      key_wr(8'h03);
      chk({7'h0, pin_override_out}, 8'h01);
      key_wr(8'h37);
      rd(lfoc_pkg::ADDR_XTAL_CTRL);
      chk(rv, 8'h03);
      key_wr(8'h00);
      wait_stat(lfoc_pkg::STAT_XT_BIT, 1'b0, 10);
      key_wr(8'h01);
      xtal_req_in <= 4'h1;
      repeat (3600) @(posedge sys_clk_in);
      rd(lfoc_pkg::ADDR_STATUS);
      chk({7'h0, rv[lfoc_pkg::STAT_XT_BIT]}, 8'h00);
      wait_stat(lfoc_pkg::STAT_XT_BIT, 1'b1, 400);
      repeat (20) @(posedge sys_clk_in);
      chk({7'h0, xtal_gate_out}, 8'h01);
      xtal_req_in <= 4'h0;
      repeat (4) @(posedge sys_clk_in);
      rd(lfoc_pkg::ADDR_STATUS);
      chk({7'h0, rv[lfoc_pkg::STAT_XT_BIT]}, 8'h00);
      key_wr(8'h00);
      wait_stat(lfoc_pkg::STAT_XT_BIT, 1'b0, 10);
      wr(lfoc_pkg::ADDR_XTAL_CTRL, 8'h04);
      chk({7'h0, xtal_ext_clock_out}, 8'h01);
      key_wr(8'h05);
      xtal_req_in <= 4'h8;
      wait_stat(lfoc_pkg::STAT_XT_BIT, 1'b1, 20);
      chk({7'h0, xtal_power_out}, 8'h00);
      xtal_req_in <= 4'h0;
      key_wr(8'h07);
      repeat (8) @(posedge sys_clk_in);
      rd(lfoc_pkg::ADDR_STATUS);
      chk({7'h0, rv[lfoc_pkg::STAT_XT_BIT]}, 8'h00);
      xtal_req_in <= 4'h1;
      repeat (4) @(posedge sys_clk_in);
      chk({7'h0, xtal_gate_out}, 8'h00);
      repeat (8) @(posedge sys_clk_in);
      chk({7'h0, xtal_gate_out}, 8'h01);
      rd(lfoc_pkg::ADDR_STATUS);
      chk({7'h0, rv[lfoc_pkg::STAT_XT_BIT]}, 8'h01);
      xtal_req_in <= 4'h0;
   endtask
   task automatic t_ulp();
      wr(lfoc_pkg::ADDR_ULP_CTRL, 8'h02);
      chk({7'h0, ulp_power_out}, 8'h01);
      rd(lfoc_pkg::ADDR_STATUS);
      chk({7'h0, rv[lfoc_pkg::STAT_ULP_BIT]}, 8'h00);
      ulp_req_in <= 4'h2;
      repeat (10) @(posedge sys_clk_in);
      chk({7'h0, ulp_gate_out}, 8'h00);
      repeat (20) @(posedge sys_clk_in);
      chk({7'h0, ulp_gate_out}, 8'h01);
      ulp_req_in <= 4'h0;
      wr(lfoc_pkg::ADDR_ULP_CTRL, 8'h00);
      repeat (4) @(posedge sys_clk_in);
      chk({7'h0, ulp_power_out}, 8'h00);
      ulp_req_in <= 4'h4;
      repeat (100) @(posedge sys_clk_in);
      chk({7'h0, ulp_gate_out}, 8'h00);
      repeat (250) @(posedge sys_clk_in);
      chk({7'h0, ulp_gate_out}, 8'h01);
      ulp_req_in <= 4'h0;
   endtask
   task automatic t_lock();
      do_reset(1'b1, 1'b1);
      rd(lfoc_pkg::ADDR_TEMP_CAL);
      chk(rv, {4'h8, lfoc_pkg::TRIM_FREQ20});
      wr(lfoc_pkg::ADDR_TEMP_CAL, 8'h05);
      chk({4'h0, temp_slope_trim_out}, {4'h0, lfoc_pkg::TRIM_FREQ20});
   endtask
   initial begin
      do_reset(1'b0, 1'b0);
      t_regs();
      t_xtal();
      t_ulp();
      t_lock();
      finish_test();
   end
endmodule
